// >>> vndi_top.sv
`timescale 1ns/1ps
`default_nettype none
// Digital input extension of a valve node.
module vndi_top #(
  parameter int unsigned FLASH_HALF = vndi_pkg::FLASH_HALF_CYC
) (
  input wire logic clk_sys, // System clock, 100 MHz.
  input wire logic srst, // Synchronous reset, active high.
  input wire logic ce, // Clock enable; low freezes all state.
  input wire logic [1:0] input_socket_one, // Pins 4 (bit 0) and 2 (bit 1).
  input wire logic [1:0] input_socket_two, // Pins 4 (bit 0) and 2 (bit 1).
  input wire logic [1:0] input_socket_three, // Pins 4 (bit 0) and 2 (bit 1).
  input wire logic [1:0] input_socket_four, // Pins 4 (bit 0) and 2 (bit 1).
  input wire logic [1:0] input_socket_five, // Pins 4 (bit 0) and 2 (bit 1).
  input wire logic short_det, // Short detected at any socket (pin).
  input wire logic overload_det, // Total sensor current above limit (pin).
  input wire logic elec_fault_det, // Electronics supply out of tolerance (pin).
  input wire logic valve_fault_det, // Valve supply out of tolerance (pin).
  input wire logic [3:0] node_addr, // Address switch, 0 = automatic (pin).
  input wire logic [2:0] out_bytes_cfg, // Configured output bytes, 1..4 (pin).
  input wire logic link_cycle, // Link cycle strobe, same clock domain.
  input wire logic link_ok, // Link communication alive, same clock domain.
  input wire logic param_valid, // Parameter byte strobe, same clock domain.
  input wire logic [7:0] param_byte, // The single parameter byte.
  output var vndi_pkg::vndi_image_s image, // Node image toward the coupler.
  output logic [7:0] param_reg, // Stored parameter byte.
  output logic [9:0] input_led, // Green input indicators.
  output logic sensor_power_en, // Sensor supply switch for all sockets.
  output logic sensor_supply_led // Supply indicator.
);

  // ----------------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------------
  wire logic [9:0] raw_in = {input_socket_five, input_socket_four, input_socket_three,
                             input_socket_two, input_socket_one};
  logic [9:0] in_sync;
  logic [3:0] flt_sync;
  logic [3:0] addr_sync;
  logic [2:0] ob_sync;
  logic blink;

  vndi_sync #(.W(10)) u_sync_in (
    .clk_sys(clk_sys),
    .srst(srst),
    .ce(ce),
    .d(raw_in),
    .q(in_sync)
  );

  vndi_sync #(.W(11)) u_sync_cfg (
    .clk_sys(clk_sys),
    .srst(srst),
    .ce(ce),
    .d({out_bytes_cfg, node_addr, valve_fault_det, elec_fault_det, overload_det, short_det}),
    .q({ob_sync, addr_sync, flt_sync})
  );

  vndi_flash #(.HALF(FLASH_HALF)) u_flash (
    .clk_sys(clk_sys),
    .srst(srst),
    .ce(ce),
    .blink(blink)
  );

  // Clamp a configured output width into the legal range.
  function automatic logic [2:0] clamp_out(input logic [2:0] v);
    if (v < vndi_pkg::OUT_BYTES_MIN) begin
      clamp_out = vndi_pkg::OUT_BYTES_MIN;
    end else if (v > vndi_pkg::OUT_BYTES_MAX) begin
      clamp_out = vndi_pkg::OUT_BYTES_MAX;
    end else begin
      clamp_out = v;
    end
  endfunction

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic [9:0] in_ff;
  logic [3:0] addr_ff;
  logic [2:0] outb_ff;
  logic cfg_done_ff;
  logic [1:0] cfg_wait_ff;
  logic [7:0] param_ff;
  logic param_got_ff;
  logic pwr_ff;
  vndi_pkg::vndi_image_s image_ff;

  // Fault currently present; power follows it without memory.
  wire logic fault_now = flt_sync[0] | flt_sync[1];

  // Identity: automatic address presents a combined module.
  wire vndi_pkg::vndi_ident_e nxt_ident = (addr_ff == vndi_pkg::AUTO_ADDR) ?
                                          vndi_pkg::VNDI_ID_COMBI :
                                          vndi_pkg::VNDI_ID_VALVE;

  // Standard diagnosis byte; inputs contribute nothing.
  logic [7:0] nxt_diag;
  always_comb begin
    nxt_diag = vndi_pkg::BYTE_ZERO;
    nxt_diag[vndi_pkg::DIAG_LINK_BIT] = ~link_ok;
    nxt_diag[vndi_pkg::DIAG_ELEC_BIT] = flt_sync[2];
    nxt_diag[vndi_pkg::DIAG_VALVE_BIT] = flt_sync[3];
  end

  // Image contents assembled for the next link cycle.
  vndi_pkg::vndi_image_s nxt_image;
  always_comb begin
    nxt_image.in_byte0 = in_ff[7:0];
    nxt_image.in_byte1 = {6'h00, in_ff[9:8]};
    nxt_image.diag_std = nxt_diag;
    nxt_image.out_bytes = outb_ff;
    nxt_image.diag_bytes = outb_ff + 3'h1;
    nxt_image.in_base = addr_ff;
    nxt_image.ident = nxt_ident;
  end

  // The synchronisers are cleared by reset, so capture waits until they hold the switches.
  wire logic cfg_take = (cfg_wait_ff == vndi_pkg::CFG_WAIT);

  // Switch settings are captured once after reset release.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      addr_ff <= 4'h0;
      outb_ff <= vndi_pkg::OUT_BYTES_MIN;
      cfg_wait_ff <= 2'h0;
      cfg_done_ff <= 1'b0;
    end else if (ce && !cfg_done_ff) begin
      if (cfg_take) begin
        addr_ff <= addr_sync;
        outb_ff <= clamp_out(ob_sync);
        cfg_done_ff <= 1'b1;
      end else begin
        cfg_wait_ff <= cfg_wait_ff + 2'h1;
      end
    end
  end

  // Only the first parameter byte is accepted; no input parameters exist.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      param_ff <= vndi_pkg::PARAM_RESET;
      param_got_ff <= 1'b0;
    end else if (ce && param_valid && !param_got_ff) begin
      param_ff <= param_byte;
      param_got_ff <= 1'b1;
    end
  end

  // Sampled inputs and sensor power follow the pins each cycle.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      in_ff <= vndi_pkg::INPUTS_RESET;
      pwr_ff <= 1'b0;
    end else if (ce) begin
      in_ff <= in_sync;
      pwr_ff <= ~fault_now;
    end
  end

  // Image refreshed on each link cycle strobe.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      image_ff <= '0;
    end else if (ce && link_cycle) begin
      image_ff <= nxt_image;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign image = image_ff;
  assign param_reg = param_ff;
  assign input_led = in_ff;
  assign sensor_power_en = pwr_ff;
  assign sensor_supply_led = pwr_ff | (flt_sync[1] & blink);

endmodule
`default_nettype wire

// >>> vndi_pkg.sv
// Operation
// - Node occupies one to four output bytes and two to five diagnosis bytes.
// - Sample ten sensor inputs, two per each of five sockets.
// - Node address decides where input bytes sit in the coupler image.
// - Address zero presents the node as a combined input/output module.
// - Input image is exactly two bytes, byte 0 first.
// - Socket n pin 4 maps to bit 2(n-1), pin 2 to the next bit.
// - Ten green indicators, one per input, lit while the input is active.
// - Inputs add no diagnosis data; diagnosis equals the plain valve node.
// - No input parameters beyond the single valve parameter byte.
// - Short or overload removes sensor power from all five sockets together.
// - Overload is not latched; power returns once the fault clears.
// - Diagnosis byte bit 7 link loss, bit 0 electronics, bit 1 valve supply.
package vndi_pkg;

  // ----------------------------------------------------------------------
  // Sizes and field positions
  // ----------------------------------------------------------------------
  localparam int unsigned NUM_SOCKETS = 5;
  localparam int unsigned NUM_INPUTS = 10;
  localparam int unsigned IN_BYTES = 2;
  localparam logic [2:0] OUT_BYTES_MIN = 3'h1;
  localparam logic [2:0] OUT_BYTES_MAX = 3'h4;
  localparam int unsigned DIAG_LINK_BIT = 7;
  localparam int unsigned DIAG_VALVE_BIT = 1;
  localparam int unsigned DIAG_ELEC_BIT = 0;
  localparam logic [3:0] AUTO_ADDR = 4'h0;
  localparam logic [7:0] PARAM_RESET = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [9:0] INPUTS_RESET = 10'h000;

  // ----------------------------------------------------------------------
  // Timing: flash period of the sensor supply indicator
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned FLASH_HALF_MS = 250;
  localparam int unsigned FLASH_HALF_CYC = FLASH_HALF_MS * 1000000 / CLK_PERIOD_NS;
  // Enabled edges after reset before the switch synchronisers hold pin values.
  localparam logic [1:0] CFG_WAIT = 2'h2;

  // Module identity presented to the coupler.
  typedef enum logic [1:0] {
    VNDI_ID_VALVE = 2'b00,
    VNDI_ID_COMBI = 2'b01,
    VNDI_ID_INPUT = 2'b10
  } vndi_ident_e;

  // Link-side image of this node.
  typedef struct packed {
    logic [7:0] in_byte1;
    logic [7:0] in_byte0;
    logic [7:0] diag_std;
    logic [2:0] out_bytes;
    logic [2:0] diag_bytes;
    logic [3:0] in_base;
    vndi_ident_e ident;
  } vndi_image_s;

  // Supply monitor results.
  typedef struct packed {
    logic link_lost;
    logic valve_fault;
    logic elec_fault;
  } vndi_supply_s;

endpackage

// >>> vndi_sync.sv
`timescale 1ns/1ps
`default_nettype none
// Two-flop synchroniser bank for pin inputs.
module vndi_sync #(
  parameter int unsigned W = 1
) (
  input wire logic clk_sys, // System clock.
  input wire logic srst, // Synchronous reset.
  input wire logic ce, // Clock enable.
  input wire logic [W-1:0] d, // Asynchronous input.
  output logic [W-1:0] q // Synchronised output.
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  // ----------------------------------------------------------------------
  // Two stages; the first is read only by the second.
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else if (ce) begin
      meta_ff <= d;
      sync_ff <= meta_ff;
    end
  end

  assign q = sync_ff;

endmodule
`default_nettype wire

// >>> vndi_flash.sv
`timescale 1ns/1ps
`default_nettype none
// Free-running square wave used to flash an indicator.
module vndi_flash #(
  parameter int unsigned HALF = 25000000
) (
  input wire logic clk_sys, // System clock.
  input wire logic srst, // Synchronous reset.
  input wire logic ce, // Clock enable.
  output logic blink // Flash waveform.
);

  logic [31:0] cnt_ff;
  logic blink_ff;
  wire logic wrap = (cnt_ff == 32'(HALF - 1));

  // ----------------------------------------------------------------------
  // Toggle the output every HALF cycles.
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cnt_ff <= 32'h0;
      blink_ff <= 1'b0;
    end else if (ce) begin
      cnt_ff <= wrap ? 32'h0 : cnt_ff + 32'h1;
      if (wrap) begin
        blink_ff <= ~blink_ff;
      end
    end
  end

  assign blink = blink_ff;

endmodule
`default_nettype wire

// >>> vndi_sva.sv
`timescale 1ns/1ps
`default_nettype none
// -------------------------------
// Checker on the top-level ports.
// -------------------------------
module vndi_sva (
  input wire logic clk_sys, // Clock.
  input wire logic srst, // Reset.
  input wire logic ce, // Enable.
  input wire logic [1:0] input_socket_one, // Socket 1.
  input wire logic [1:0] input_socket_two, // Socket 2.
  input wire logic [1:0] input_socket_three, // Socket 3.
  input wire logic [1:0] input_socket_four, // Socket 4.
  input wire logic [1:0] input_socket_five, // Socket 5.
  input wire logic short_det, // Short.
  input wire logic overload_det, // Overload.
  input wire logic link_cycle, // Refresh.
  input wire vndi_pkg::vndi_image_s image, // Image.
  input wire logic [9:0] input_led, // Indicators.
  input wire logic sensor_power_en // Power.
);
  logic [2:0] run_ff;
  wire logic ok3 = &run_ff;
  wire logic flt = short_det | overload_det;
  wire logic upd = ce & link_cycle;
  wire logic [9:0] pins = {input_socket_five, input_socket_four, input_socket_three, input_socket_two,
    input_socket_one};
  // Records whether the last three edges ran enabled and out of reset.
  always_ff @(posedge clk_sys) begin
    run_ff <= {run_ff[1:0], ce & ~srst};
  end
  default clocking dcb @(posedge clk_sys); endclocking
  default disable iff (srst);
  property p_led; ok3 |-> input_led == $past(pins, 3); endproperty
  a_led: assert property (p_led) else $error("led lags pins");
  property p_off; ok3 && $past(flt, 3) |-> !sensor_power_en; endproperty
  a_off: assert property (p_off) else $error("power on in fault");
  property p_on; ok3 && !$past(flt, 3) |-> sensor_power_en; endproperty
  a_on: assert property (p_on) else $error("power stays off");
  property p_map; upd |=> {image.in_byte1, image.in_byte0} == {6'h00, $past(input_led)}; endproperty
  a_map: assert property (p_map) else $error("input bytes wrong");
  property p_hold; !upd |=> $stable({image.in_byte1, image.in_byte0}); endproperty
  a_hold: assert property (p_hold) else $error("input bytes moved");
  property p_zero; image.in_byte1[7:2] == 6'h00; endproperty
  a_zero: assert property (p_zero) else $error("unused bits set");
  property p_ident;
    upd |=> image.ident == (image.in_base == 4'h0 ? vndi_pkg::VNDI_ID_COMBI : vndi_pkg::VNDI_ID_VALVE);
  endproperty
  a_ident: assert property (p_ident) else $error("identity wrong");
  property p_dlen; upd |=> image.diag_bytes == image.out_bytes + 3'h1; endproperty
  a_dlen: assert property (p_dlen) else $error("diag length wrong");
  c_short: cover property (short_det ##3 !sensor_power_en);
  c_ovl: cover property (overload_det ##3 !sensor_power_en);
  c_auto: cover property (upd ##1 image.ident == vndi_pkg::VNDI_ID_COMBI);
endmodule
bind vndi_top vndi_sva vndi_sva_i (.clk_sys(clk_sys), .srst(srst), .ce(ce), .input_socket_one(input_socket_one),
  .input_socket_two(input_socket_two), .input_socket_three(input_socket_three), .input_socket_four(input_socket_four),
  .input_socket_five(input_socket_five), .short_det(short_det), .overload_det(overload_det), .link_cycle(link_cycle),
  .image(image), .input_led(input_led), .sensor_power_en(sensor_power_en));
`default_nettype wire

// >>> vndi_cpl.sv
`timescale 1ns/1ps
`default_nettype none
// -------------
// Coupler model.
// -------------
module vndi_cpl #(
  parameter int unsigned PER = 5
) (
  input wire logic clk_sys, // Clock.
  input wire logic srst, // Reset.
  input wire logic [1:0] mode, // Bit 0 long cycle, bit 1 link lost.
  input wire logic again, // Resend command.
  input wire logic [7:0] pbyte, // Byte to send.
  output logic link_cycle = 1'b0, // Refresh.
  output logic link_ok = 1'b0, // Alive.
  output logic param_valid = 1'b0, // Strobe.
  output logic [7:0] param_byte = 8'h00 // Data.
);
  int cnt = 0;
  logic sent = 1'b0;
  // Strobes the link and sends one byte after reset; idle data toggles so stale values never pass.
  always @(posedge clk_sys) begin
    cnt <= (srst || cnt == 0) ? (mode[0] ? 3 * PER : PER) - 1 : cnt - 1;
    link_cycle <= !srst && cnt == 0;
    link_ok <= !srst && !mode[1];
    param_valid <= !srst && (!sent || again);
    param_byte <= (!srst && (!sent || again)) ? pbyte : ~param_byte;
    sent <= !srst;
  end
endmodule
`default_nettype wire

// >>> testbench.sv
`timescale 1ns/1ps
`default_nettype none
// --------------------
// Self-checking bench.
// --------------------
module testbench;
  logic clk_sys = 1'b0, srst = 1'b1, ce = 1'b1, again = 1'b0, short_det = 1'b0, overload_det = 1'b0;
  logic elec = 1'b0, valve = 1'b0, link_cycle, link_ok, param_valid, power, sup_led;
  logic [1:0] mode = 2'h0;
  logic [3:0] addr = 4'h0;
  logic [2:0] obytes = 3'h1;
  logic [7:0] pbyte = 8'h00, param_byte, param_reg;
  logic [9:0] pins = 10'h000, led;
  logic [31:0] seed = 32'hF4A81108;
  vndi_pkg::vndi_image_s image;
  int n_fail = 0, checked = 0, age = 0, got = 0, e_img = 0, e_par = 0, e_ob = 0;
  int q_led[$], q_pow[$], q_ovl[$];
  localparam int HALF = 4;
  always #5 clk_sys = ~clk_sys;
  vndi_cpl vndi_cpl_i (.clk_sys(clk_sys), .srst(srst), .mode(mode), .again(again), .pbyte(pbyte),
    .link_cycle(link_cycle), .link_ok(link_ok), .param_valid(param_valid), .param_byte(param_byte));
  vndi_top #(.FLASH_HALF(HALF)) vndi_top_i (.clk_sys(clk_sys), .srst(srst), .ce(ce), .input_socket_one(pins[1:0]),
    .input_socket_two(pins[3:2]), .input_socket_three(pins[5:4]), .input_socket_four(pins[7:6]),
    .input_socket_five(pins[9:8]), .short_det(short_det), .overload_det(overload_det), .elec_fault_det(elec),
    .valve_fault_det(valve), .node_addr(addr), .out_bytes_cfg(obytes), .link_cycle(link_cycle), .link_ok(link_ok),
    .param_valid(param_valid), .param_byte(param_byte), .image(image), .param_reg(param_reg), .input_led(led),
    .sensor_power_en(power), .sensor_supply_led(sup_led));
  // Reference model: three-edge pipes for inputs and supply, image refresh, first byte kept.
  always @(posedge clk_sys) begin
    if (srst) begin
      q_led = '{0, 0, 0};
      q_pow = '{0, 0, 0};
      q_ovl = '{0, 0, 0};
      e_img = 0;
      e_par = 0;
      got = 0;
      age = 0;
    end else if (ce) begin
      if (link_cycle) e_img = q_led[0];
      q_led.push_back(pins);
      void'(q_led.pop_front());
      q_pow.push_back(!(short_det || overload_det));
      void'(q_pow.pop_front());
      q_ovl.push_back(overload_det);
      void'(q_ovl.pop_front());
      if (param_valid && got == 0) begin
        e_par = param_byte;
        got = 1;
      end
      age++;
    end
  end
  function automatic logic [31:0] xs(logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction
  task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic summarize();
    if (n_fail == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // One clock: compare indicators, input bytes and parameter, and after three edges power and supply LED, then drive fresh random pins.
  task automatic cycle();
    @(posedge clk_sys);
    #1;
    check("led", led, q_led[0]);
    check("inbytes", {image.in_byte1, image.in_byte0}, e_img);
    check("param", param_reg, e_par);
    if (age > 3) check("power", power, q_pow[0]);
    if (age > 3) check("supled", sup_led, q_pow[0] | (q_ovl[1] & ((age / HALF) % 2)));
    seed = xs(seed);
    pins = seed[9:0];
  endtask
  task automatic await_link();
    int k;
    for (k = 0; k < 100 && link_cycle !== 1'b1; k++) cycle();
    if (k == 100) begin
      n_fail++;
      summarize();
    end
  endtask
  // Four power-ups with different address, width, link mode and faults.
  initial begin
    for (int r = 0; r < 4; r++) begin
      srst = 1'b1;
      addr = (r == 0) ? 4'h0 : 4'(seed % 14 + 1);
      obytes = 3'(r * 3);
      e_ob = (obytes == 3'h0) ? 1 : (obytes > 3'h4) ? 4 : obytes;
      {mode, valve, elec} = {r[1], r[0], r[1], r[0]};
      pbyte = seed[15:8];
      repeat (12) cycle();
      srst = 1'b0;
      await_link();
      cycle();
      check("ident", image.ident, (r == 0) ? vndi_pkg::VNDI_ID_COMBI : vndi_pkg::VNDI_ID_VALVE);
      check("base", image.in_base, addr);
      check("obytes", image.out_bytes, e_ob);
      check("dbytes", image.diag_bytes, e_ob + 1);
      check("diag", image.diag_std, {mode[1], 5'h00, valve, elec});
      repeat (30) cycle();
      {short_det, overload_det} = {r != 1, r[0]};
      repeat (9) cycle();
      {short_det, overload_det} = 2'b00;
      repeat (9) cycle();
      ce = 1'b0;
      repeat (5) cycle();
      ce = 1'b1;
      pbyte = ~pbyte;
      again = 1'b1;
      cycle();
      again = 1'b0;
      repeat (20) cycle();
    end
    summarize();
  end
endmodule
`default_nettype wire
